// ---- core/oprm_map.svh ----
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 125 MHz clock, APB with 32-bit data
// Notes: every register is one aligned word
`ifndef OPRM_MAP_SVH
`define OPRM_MAP_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define OPRM_CLK_HZ 125000000
`define OPRM_TICK_MS 1
`define OPRM_TICK_CYC ((`OPRM_CLK_HZ / 1000) * `OPRM_TICK_MS)
`define OPRM_TIME_MIN_MS 14'h0001
`define OPRM_TIME_MAX_MS 14'h270F

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OPRM_A_CTRL 8'h00
`define OPRM_A_OUTST 8'h04
`define OPRM_A_DLY0 8'h08
`define OPRM_A_DLY1 8'h0C
`define OPRM_A_PLS0 8'h10
`define OPRM_A_PLS1 8'h14
`define OPRM_A_WIN 8'h18
`define OPRM_A_RATE0 8'h1C
`define OPRM_A_RATE1 8'h20
`define OPRM_A_RNGACT 8'h24
`define OPRM_A_LOGSEL 8'h28
`define OPRM_A_LOGDAT 8'h2C
`define OPRM_A_LOGCNT 8'h30
`define OPRM_A_LIM 8'h40
`define OPRM_A_LIM_END 8'h5F

// ----------------------------------------------------------------
// control word fields and reset value; history depth
// ----------------------------------------------------------------
`define OPRM_C_MODE0 1:0
`define OPRM_C_MODE1 3:2
`define OPRM_C_MANUAL 4
`define OPRM_C_MANOUT 6:5
`define OPRM_C_RESET 32'h0000_0000
`define OPRM_LOG_DEPTH 7'h40

`endif

// ---- core/oprm_pkg.sv ----
// Purpose: types shared by the output pulse and rate meter
// Assumes: the map header holds all numbers
// Notes: none
package oprm_pkg;

   // output shaping mode per output
   typedef enum logic [1:0] {
      ModeNormal,
      ModeDelay,
      ModePulse,
      ModeDelayPulse
   } oprm_mode_t;

   typedef enum logic [1:0] {
      OutIdle,
      OutWait,
      OutOn,
      OutDone
   } oprm_ost_t;

   // one rate range: limits are signed 32-bit rate values
   typedef struct packed {
      logic signed [31:0] lower;
      logic signed [31:0] upper;
   } oprm_range_t;

   // bus request as seen by the slave
   typedef struct packed {
      logic sel;
      logic enable;
      logic write;
      logic [7:0] addr;
      logic [31:0] wdata;
   } oprm_apb_req_t;

endpackage

// ---- core/oprm_top.sv ----
// Behaviour
// - turn-on delay 1 to 9999 ms
// - pulse duration 1 to 9999 ms
// - modes normal, delay, pulse, delay+pulse
// - sequence starts on pattern rising edge
// - normal mode follows pattern without delay
// - output stays off until delay elapses
// - pulse on at once, off after duration
// - status shows true physical output state
// - pattern fall cancels timing, output off
// - manual on bypasses delay and pulse
// - after pulse, internal on blocks retrigger
// - rate once per 1-9999 ms window
// - rate is signed end minus start
// - two rate ranges per counter
// - range set/reset patterns override outputs; only cntVal1 patterns are writable, cntVal0 ones stay zero
// - multiplied counts included in rate
// - preset/reset keeps previous rate value
// - ring counter wrap keeps rate correct
// - history keeps 64 newest rates per counter
// - each entry is one signed 32-bit value
// - single entry read gives youngest value
// - full history overwrites oldest entry
// - range active when lower<=rate<=upper
// - error when upper not above lower
// - manual control bit selects host bits
//
// Purpose: shape two digital outputs and measure two counter rates
// Assumes: counter values are sampled each cycle; 125 MHz clock
// Notes: history entry index 0 is the youngest value
//
// Added by the designer: the APB register port and the address map.
`timescale 1ns/10ps
`include "oprm_map.svh"

module oprm_top (
   input wire logic clk, // unit clock
   input wire logic rst_b, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error
   input wire logic [31:0] outPattern, // unit output pattern
   input wire logic [31:0] cntVal0, // counter 1 value, multiplied
   input wire logic [31:0] cntVal1, // counter 2 value, multiplied
   input wire logic [1:0] cntLoad, // counter preset or reset pulse
   output logic [31:0] outEffective, // pattern after range overrides
   output logic [1:0] physOut, // physical digital outputs
   output logic cfgError // rate range limit error
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [31:0] ctrl;
      logic [1:0][13:0] dly;
      logic [1:0][13:0] pls;
      logic [13:0] win;
      logic [16:0] tickCnt;
      logic [13:0] winCnt;
      logic [1:0][13:0] tmr;
      logic [1:0][1:0] ost;
      logic [1:0] phys;
      logic [1:0] patPrev;
      logic [31:0] outEff;
      logic [1:0][31:0] start;
      logic [1:0] loaded;
      logic [1:0][31:0] rate;
      logic [1:0][1:0] active;
      logic [1:0][1:0] rngEn;
      logic [3:0][31:0] lim;
      logic [7:0][31:0] setRst;
      logic [1:0][5:0] wrPtr;
      logic [1:0][6:0] count;
      logic [127:0][31:0] log;
      logic [6:0] logSel;
      logic [31:0] rdata;
      logic err;
   } oprm_state_t;

   oprm_state_t st_r;
   oprm_state_t st_nxt;

   // range limit word for counter c, range r, upper u
   function automatic logic [31:0] limWord(input oprm_state_t s,
         input int c, input int r, input int u);
      limWord = s.lim[c * 2 + u] ^ (r[0] ? s.setRst[c * 4 + u] : 32'h0);
   endfunction

   // inclusive window compare
   function automatic logic inRange(input logic signed [31:0] v,
         input logic signed [31:0] lo, input logic signed [31:0] hi);
      inRange = (lo <= v) && (v <= hi);
   endfunction

   logic apbAccess;
   logic apbWrite;
   logic tick;
   logic [7:0] rIdx;

   assign apbAccess = psel && penable;
   assign apbWrite = apbAccess && pwrite;
   assign pready = 1'b1;
   assign pslverr = 1'b0;
   assign prdata = st_r.rdata;
   assign physOut = st_r.phys;
   assign outEffective = st_r.outEff;
   assign cfgError = st_r.err;
   assign tick = (st_r.tickCnt == 17'(`OPRM_TICK_CYC - 1));

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [31:0] cv [2];
      logic [31:0] diff;
      logic [31:0] setM;
      logic [31:0] rstM;
      logic winEnd;
      logic rise;
      logic fall;
      oprm_pkg::oprm_mode_t md;
      logic [6:0] slot;
      st_nxt = st_r;
      cv[0] = cntVal0;
      cv[1] = cntVal1;
      diff = 32'h0;
      slot = 7'h0;
      setM = 32'h0;
      rstM = 32'h0;
      winEnd = 1'b0;
      rise = 1'b0;
      fall = 1'b0;
      md = oprm_pkg::ModeNormal;
      st_nxt.tickCnt = tick ? 17'h0 : st_r.tickCnt + 17'h1;
      winEnd = tick && (st_r.winCnt + 14'h1 >= st_r.win);
      if (tick) begin
         st_nxt.winCnt = winEnd ? 14'h0 : st_r.winCnt + 14'h1;
      end

      // two ranges per counter; set/reset override
      setM = 32'h0;
      rstM = 32'h0;
      st_nxt.err = 1'b0;
      for (int c = 0; c < 2; c++) begin
         for (int r = 0; r < 2; r++) begin
            st_nxt.active[c][r] = inRange(st_r.rate[c],
               st_r.lim[c * 2 + r * 0] , st_r.lim[c * 2 + 1]);
            if (r == 1) begin
               st_nxt.active[c][r] = inRange(st_r.rate[c],
                  limWord(st_r, c, 1, 0), limWord(st_r, c, 1, 1));
            end
            if ($signed(limWord(st_r, c, r, 1)) <=
                  $signed(limWord(st_r, c, r, 0))) begin
               st_nxt.err = 1'b1;
            end
            if (st_r.active[c][r] && st_r.rngEn[c][r]) begin
               setM = setM | st_r.setRst[c * 4 + r * 2];
               rstM = rstM | st_r.setRst[c * 4 + r * 2 + 1];
            end
         end
      end
      st_nxt.outEff = (outPattern & ~rstM) | setM;

      // output shaping for outputs 0-1
      for (int o = 0; o < 2; o++) begin
         md = oprm_pkg::oprm_mode_t'(st_r.ctrl[o * 2 +: 2]);
         rise = st_r.outEff[o] && !st_r.patPrev[o];
         fall = !st_r.outEff[o] && st_r.patPrev[o];
         st_nxt.patPrev[o] = st_r.outEff[o];
         if (tick && st_r.tmr[o] != 14'h0) begin
            st_nxt.tmr[o] = st_r.tmr[o] - 14'h1;
         end
         case (oprm_pkg::oprm_ost_t'(st_r.ost[o]))
            oprm_pkg::OutIdle: begin
               // start only on a rising edge
               if (rise) begin
                  if (md == oprm_pkg::ModeDelay ||
                        md == oprm_pkg::ModeDelayPulse) begin
                     st_nxt.ost[o] = oprm_pkg::OutWait;
                     st_nxt.tmr[o] = st_r.dly[o];
                  end else begin
                     st_nxt.ost[o] = oprm_pkg::OutOn;
                     st_nxt.tmr[o] = st_r.pls[o];
                  end
               end
            end
            oprm_pkg::OutWait: begin
               if (tick && st_r.tmr[o] == 14'h1) begin
                  st_nxt.ost[o] = oprm_pkg::OutOn;
                  st_nxt.tmr[o] = st_r.pls[o];
               end
            end
            oprm_pkg::OutOn: begin
               if ((md == oprm_pkg::ModePulse ||
                     md == oprm_pkg::ModeDelayPulse) &&
                     tick && st_r.tmr[o] == 14'h1) begin
                  st_nxt.ost[o] = oprm_pkg::OutDone;
               end
            end
            oprm_pkg::OutDone: begin
               st_nxt.ost[o] = oprm_pkg::OutDone;
            end
            default: st_nxt.ost[o] = oprm_pkg::OutIdle;
         endcase
         if (fall || !st_r.outEff[o]) begin
            st_nxt.ost[o] = oprm_pkg::OutIdle;
            st_nxt.tmr[o] = 14'h0;
         end
         st_nxt.phys[o] = (st_nxt.ost[o] == oprm_pkg::OutOn);
         if (st_r.ctrl[`OPRM_C_MANUAL]) begin
            st_nxt.phys[o] = st_r.ctrl[5 + o];
         end
      end

      for (int c = 0; c < 2; c++) begin
         if (cntLoad[c]) begin
            st_nxt.loaded[c] = 1'b1;
         end
         if (winEnd) begin
            // modulo-2^32 difference survives ring wraps
            diff = cv[c] - st_r.start[c];
            st_nxt.start[c] = cv[c];
            st_nxt.loaded[c] = 1'b0;
            if (!st_r.loaded[c] && !cntLoad[c]) begin
               st_nxt.rate[c] = diff;
            end
            slot = {c[0], st_r.wrPtr[c]};
            st_nxt.log[slot] = (!st_r.loaded[c] && !cntLoad[c]) ?
               diff : st_r.rate[c];
            st_nxt.wrPtr[c] = st_r.wrPtr[c] + 6'h1;
            if (st_r.count[c] != `OPRM_LOG_DEPTH) begin
               st_nxt.count[c] = st_r.count[c] + 7'h1;
            end
         end
      end

      // bus writes
      if (apbWrite) begin
         case (paddr)
            `OPRM_A_CTRL: st_nxt.ctrl = pwdata;
            `OPRM_A_DLY0: st_nxt.dly[0] = clampMs(pwdata);
            `OPRM_A_DLY1: st_nxt.dly[1] = clampMs(pwdata);
            `OPRM_A_PLS0: st_nxt.pls[0] = clampMs(pwdata);
            `OPRM_A_PLS1: st_nxt.pls[1] = clampMs(pwdata);
            `OPRM_A_WIN: st_nxt.win = clampMs(pwdata);
            `OPRM_A_RNGACT: st_nxt.rngEn = pwdata[3:0];
            `OPRM_A_LOGSEL: st_nxt.logSel = pwdata[6:0];
            default: begin
               if (paddr >= `OPRM_A_LIM && paddr <= `OPRM_A_LIM_END) begin
                  if (paddr[4]) begin
                     st_nxt.setRst[paddr[4:2]] = pwdata;
                  end else begin
                     st_nxt.lim[paddr[3:2]] = pwdata;
                  end
               end
            end
         endcase
      end

      // bus reads, registered at the end of the setup phase
      rIdx = paddr;
      st_nxt.rdata = 32'h0;
      if (psel && !penable && !pwrite) begin
         case (paddr)
            `OPRM_A_CTRL: st_nxt.rdata = st_r.ctrl;
            `OPRM_A_OUTST: st_nxt.rdata = {30'h0, st_r.phys};
            `OPRM_A_DLY0: st_nxt.rdata = {18'h0, st_r.dly[0]};
            `OPRM_A_DLY1: st_nxt.rdata = {18'h0, st_r.dly[1]};
            `OPRM_A_PLS0: st_nxt.rdata = {18'h0, st_r.pls[0]};
            `OPRM_A_PLS1: st_nxt.rdata = {18'h0, st_r.pls[1]};
            `OPRM_A_WIN: st_nxt.rdata = {18'h0, st_r.win};
            `OPRM_A_RATE0: st_nxt.rdata = st_r.rate[0];
            `OPRM_A_RATE1: st_nxt.rdata = st_r.rate[1];
            `OPRM_A_RNGACT: st_nxt.rdata = {23'h0, st_r.err,
               st_r.active, st_r.rngEn};
            `OPRM_A_LOGSEL: st_nxt.rdata = {25'h0, st_r.logSel};
            // index 0 is the youngest entry
            `OPRM_A_LOGDAT: begin
               slot = {st_r.logSel[6],
                  6'(st_r.wrPtr[st_r.logSel[6]] - 6'h1 - st_r.logSel[5:0])};
               st_nxt.rdata = st_r.log[slot];
            end
            `OPRM_A_LOGCNT: st_nxt.rdata = {9'h0, st_r.count[1],
               9'h0, st_r.count[0]};
            default: begin
               if (paddr >= `OPRM_A_LIM && paddr <= `OPRM_A_LIM_END) begin
                  st_nxt.rdata = paddr[4] ? st_r.setRst[paddr[4:2]] :
                     st_r.lim[paddr[3:2]];
               end
            end
         endcase
      end
   end

   // clamp a programmed time into 1..9999 ms
   function automatic logic [13:0] clampMs(input logic [31:0] v);
      if (v < 32'(`OPRM_TIME_MIN_MS)) begin
         clampMs = `OPRM_TIME_MIN_MS;
      end else if (v > 32'(`OPRM_TIME_MAX_MS)) begin
         clampMs = `OPRM_TIME_MAX_MS;
      end else begin
         clampMs = v[13:0];
      end
   endfunction

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
         st_r.win <= `OPRM_TIME_MIN_MS;
         st_r.dly <= {2{`OPRM_TIME_MIN_MS}};
         st_r.pls <= {2{`OPRM_TIME_MIN_MS}};
      end else begin
         st_r <= st_nxt;
      end
   end

endmodule

// ---- sim/oprm_monitor.sv ----
// Purpose: port-level checks of output shaping, status and limits
// Assumes: configuration is learnt by snooping apb writes
// Notes: follows output 0/1 paths and range 0 limits of counter 0
`timescale 1ns/10ps
`include "oprm_map.svh"

module oprm_monitor (
   input wire logic clk, // unit clock
   input wire logic rst_b, // async reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic [31:0] outPattern, // unit pattern
   input wire logic [31:0] outEffective, // pattern after ranges
   input wire logic [1:0] physOut, // physical outputs
   input wire logic cfgError // limit error
);
   logic [6:0] ctl_r;
   logic [3:0] rngEn_r;
   logic [1:0] age_r;
   logic signed [31:0] lo_r;
   logic wrEn;
   logic steady;

   assign wrEn = psel && penable && pwrite && pready;
   // settle time after a config write, so old state is not judged
   assign steady = age_r[1];

   // ----------------------------------------
   // snooped configuration
   // ----------------------------------------
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ctl_r <= 7'h00;
         rngEn_r <= 4'h0;
         age_r <= 2'h3;
         lo_r <= 32'sh0;
      end else begin
         if (wrEn && paddr == `OPRM_A_CTRL) ctl_r <= pwdata[6:0];
         if (wrEn && paddr == `OPRM_A_RNGACT) rngEn_r <= pwdata[3:0];
         if (wrEn && paddr == `OPRM_A_LIM) lo_r <= pwdata;
         if (wrEn && paddr inside {`OPRM_A_CTRL, `OPRM_A_RNGACT})
            age_r <= 2'h0;
         else if (age_r != 2'h3) age_r <= age_r + 2'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);

   pass_through_a: assert property (steady && rngEn_r == 4'h0
      |-> outEffective == $past(outPattern)) else $error("pattern lost");
   normal_follow_a: assert property (steady && ctl_r[4:0] == 5'h00
      |-> physOut[0] == $past(outEffective[0])) else $error("normal lag");
   fall_off_a: assert property (steady && !ctl_r[4]
      && $fell(outEffective[1]) |=> !physOut[1]) else $error("not off");
   delay_hold_a: assert property (steady && !ctl_r[4] && ctl_r[0]
      && $rose(outEffective[0]) |=> !physOut[0] [*2])
      else $error("delay skipped");
   pulse_on_a: assert property (steady && ctl_r[4:0] inside {5'h02, 5'h0A}
      && $rose(outEffective[0]) |=> physOut[0]) else $error("pulse late");
   manual_drive_a: assert property (steady && ctl_r[4]
      |-> physOut == ctl_r[6:5]) else $error("manual level wrong");
   status_read_a: assert property (psel && penable && !pwrite
      && paddr == `OPRM_A_OUTST |-> prdata[1:0] == $past(physOut))
      else $error("status not physical");
   limit_error_a: assert property (wrEn
      && paddr == `OPRM_A_LIM + 8'h04 && $signed(pwdata) <= lo_r
      |-> ##[1:3] cfgError) else $error("no limit error");

   cover property (steady && ctl_r[4]);
   cover property ($rose(physOut[0]));
   cover property ($rose(cfgError));
endmodule

bind oprm_top oprm_monitor mon (
   .clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .outPattern(outPattern),
   .outEffective(outEffective), .physOut(physOut), .cfgError(cfgError)
);

// ---- sim/oprm_host_model.sv ----
// Purpose: host processor side, an apb master with register tasks
// Assumes: caller is at or after a rising edge
// Notes: released write data is inverted so stale values never pass
`timescale 1ns/10ps
`include "oprm_map.svh"

module oprm_host_model (
   input wire logic clk, // unit clock
   input wire logic pready, // slave ready
   input wire logic [31:0] prdata, // read data
   output logic psel, // select
   output logic penable, // enable
   output logic pwrite, // direction
   output logic [7:0] paddr, // byte address
   output logic [31:0] pwdata // write data
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
   end

   // ----------------------------------------
   // bus transfers
   // ----------------------------------------
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      pwdata <= ~d;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      xfer(1'b1, a, d, q);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] q);
      xfer(1'b0, a, 32'h0, q);
   endtask

   // age field limits a request to 64 entries
   task automatic log_rd(input logic c, input logic [5:0] age,
      output logic [31:0] q);
      wr(`OPRM_A_LOGSEL, {25'h0, c, age});
      rd(`OPRM_A_LOGDAT, q);
   endtask
endmodule

// ---- sim/tb_top.sv ----
// Purpose: self-checking bench for output shaping and limit checks
// Assumes: 1 ms tick is 125000 cycles, so no timer or window expires
// Notes: delays are set long so only their start can be seen
`timescale 1ns/10ps
`include "oprm_map.svh"

module tb_top;
   logic clk, rst_b, psel, penable, pwrite, pready, pslverr, cfgError;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, outPattern, cnt0, outEffective, q;
   logic [1:0] cntLoad, physOut;
   int fails, checks;

   oprm_top dut (.clk(clk), .rst_b(rst_b), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .outPattern(outPattern), .cntVal0(cnt0),
      .cntVal1(~cnt0), .cntLoad(cntLoad), .outEffective(outEffective),
      .physOut(physOut), .cfgError(cfgError));
   oprm_host_model host (.clk(clk), .pready(pready), .prdata(prdata),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt0 <= 32'h0;
      end else begin
         cnt0 <= cnt0 + 32'h1;
      end
   end

   // ----------------------------------------
   // checks and scenarios
   // ----------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      #1;
      checks++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got,
            exp);
      end
   endtask

   task t_defaults;
      host.rd(`OPRM_A_CTRL, q);
      chk(q, `OPRM_C_RESET);
      host.rd(`OPRM_A_PLS1, q);
      chk(q, 32'h1);
      host.rd(8'h3C, q);
      chk(q, 32'h0);
      host.rd(`OPRM_A_LOGCNT, q);
      chk(q, 32'h0);
      host.log_rd(1'b0, 6'h00, q);
      chk(q, 32'h0);
      host.wr(`OPRM_A_WIN, 32'h0);
      host.rd(`OPRM_A_WIN, q);
      chk(q, 32'h1);
   endtask

   task t_modes;
      logic [1:0] e;
      host.wr(`OPRM_A_DLY0, 32'h2710);
      host.rd(`OPRM_A_DLY0, q);
      chk(q, 32'h270F);
      host.wr(`OPRM_A_DLY1, 32'h270F);
      host.wr(`OPRM_A_PLS0, 32'h270F);
      host.wr(`OPRM_A_PLS1, 32'h270F);
      for (int i = 0; i < 4; i++) begin
         host.wr(`OPRM_A_CTRL, {28'h0, i[1:0], i[1:0]});
         @(posedge clk);
         outPattern <= 32'h3;
         repeat (4) @(posedge clk);
         e = i[0] ? 2'h0 : 2'h3;
         chk(outEffective, 32'h3);
         chk({30'h0, physOut}, {30'h0, e});
         host.rd(`OPRM_A_OUTST, q);
         chk(q, {30'h0, e});
         @(posedge clk);
         outPattern <= 32'h0;
         repeat (3) @(posedge clk);
         chk({30'h0, physOut}, 32'h0);
      end
   endtask

   task t_manual;
      host.wr(`OPRM_A_CTRL, 32'h35);
      @(posedge clk);
      outPattern <= 32'h3;
      repeat (3) @(posedge clk);
      chk({30'h0, physOut}, 32'h1);
      host.wr(`OPRM_A_CTRL, 32'h55);
      repeat (3) @(posedge clk);
      chk({30'h0, physOut}, 32'h2);
      @(posedge clk);
      outPattern <= 32'h0;
      host.wr(`OPRM_A_CTRL, 32'h0);
   endtask

   task t_limits;
      // valid limits everywhere first, so the error flag must clear
      host.wr(`OPRM_A_LIM + 8'h04, 32'h5);
      host.wr(`OPRM_A_LIM + 8'h0C, 32'h5);
      repeat (3) @(posedge clk);
      chk({31'h0, cfgError}, 32'h0);
      host.wr(`OPRM_A_LIM, 32'h5);
      host.wr(`OPRM_A_LIM + 8'h04, 32'h5);
      repeat (3) @(posedge clk);
      chk({31'h0, cfgError}, 32'h1);
      host.rd(`OPRM_A_RNGACT, q);
      chk({31'h0, q[8]}, 32'h1);
   endtask

   task finish_test;
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   initial begin
      repeat (5000) @(posedge clk);
      fails++;
      finish_test;
   end

   initial begin
      rst_b = 1'b0;
      outPattern = 32'h0;
      cntLoad = 2'h0;
      repeat (4) @(posedge clk);
      rst_b <= 1'b1;
      t_defaults;
      t_modes;
      t_manual;
      t_limits;
      finish_test;
   end
endmodule
